// ==== core/msc1_startup_cfg.sv ====
/*
 * first start-up configuration word of a sensorless motor controller,
 * with the start-up sequencer that consumes it.
 * assumes: one clock, all handshake inputs are on clk; register port is
 * a plain strobe port with read data one cycle after the read strobe.
 */
// Strobed register access was chosen for this implementation.
// What this block does
// - configuration word sits at 0x84, 32 bits, resets to all zeros
// - two-bit method picks single align, double align, detection or slow cycle
// - four-bit ramp rate sets current rise speed; code Fh means unlimited
// - four-bit duration holds alignment 10 ms up to 10 s
// - four-bit current cap; codes Eh and Fh reserved, never used
// - three-bit pulse rate, 50 Hz to 10000 Hz for position detection
// - release bit: 0 brakes phases, 1 tristates them after detection
// - repeat field runs detection once or averages two to four runs
// - brake enable permits active braking during deceleration
// - reverse select: 0 forward-drive profile, 1 dedicated reverse profile
`timescale 1ns/1ps
`include "msc1_map.svh"

module msc1_startup_cfg #(
    parameter int CYCLES_PER_MS = `MSC1_MS_CYCLES
) (
    input  wire logic              clk,            // 125 MHz clock
    input  wire logic              rst_n,          // async reset, active low
    input  wire logic [7:0]        addr,           // byte address
    input  wire logic [31:0]       wrData,         // write data
    input  wire logic              wrStb,          // write strobe
    input  wire logic              rdStb,          // read strobe
    output logic [31:0]            rdData,         // read data, cycle after rdStb
    input  wire logic              startReq,       // motor start begins
    input  wire logic              stopReq,        // abort start-up
    input  wire logic              detectRunDone,  // one detection run finished
    input  wire logic              slowCycleDone,  // slow first cycle finished
    output msc1_pkg::msc1_cfg_s    activeCfg,      // snapshot held during start-up
    output msc1_pkg::msc1_state_e  seqState,       // sequencer state
    output logic                   alignActive,    // rotor alignment current on
    output logic                   detectPulse,    // one-cycle detection pulse
    output logic                   bridgeBrake,    // phases shorted after detection
    output logic                   bridgeTristate, // phases released after detection
    output logic                   rampUnlimited,  // no current ramp limit
    output logic                   capCodeError,   // reserved cap code was written
    output logic                   startupDone     // start-up finished, one cycle
);

    ////////////////////////////////////////////////////////////////////
    // elaboration check
    if (CYCLES_PER_MS < 1) begin : g_bad_ms
        $error("CYCLES_PER_MS must be at least one");
    end

    localparam logic [31:0] CyclesPerSec =
        32'(CYCLES_PER_MS * `MSC1_MS_PER_S);
    localparam logic [31:0] MsLast = 32'(CYCLES_PER_MS - 1);

    ////////////////////////////////////////////////////////////////////
    // lookup tables
    function automatic logic [13:0] align_ms(input logic [3:0] code);
        case (code)
            4'h0:    align_ms = 14'd10;
            4'h1:    align_ms = 14'd50;
            4'h2:    align_ms = 14'd100;
            4'h3:    align_ms = 14'd200;
            4'h4:    align_ms = 14'd300;
            4'h5:    align_ms = 14'd400;
            4'h6:    align_ms = 14'd500;
            4'h7:    align_ms = 14'd750;
            4'h8:    align_ms = 14'd1000;
            4'h9:    align_ms = 14'd1500;
            4'ha:    align_ms = 14'd2000;
            4'hb:    align_ms = 14'd3000;
            4'hc:    align_ms = 14'd4000;
            4'hd:    align_ms = 14'd5000;
            4'he:    align_ms = 14'd7500;
            default: align_ms = 14'd10000;
        endcase
    endfunction

    function automatic logic [31:0] pulse_period(input logic [2:0] code);
        logic [31:0] hz;
        case (code)
            3'h0:    hz = 32'd50;
            3'h1:    hz = 32'd100;
            3'h2:    hz = 32'd250;
            3'h3:    hz = 32'd500;
            3'h4:    hz = 32'd1000;
            3'h5:    hz = 32'd2000;
            3'h6:    hz = 32'd5000;
            default: hz = 32'd10000;
        endcase
        pulse_period = (CyclesPerSec / hz > 32'h1) ? CyclesPerSec / hz : 32'h1;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // configuration word
    logic [31:0] cfgWord_ff;
    logic        capErr_ff;
    logic        cfgWrite;

    assign cfgWrite = wrStb && (addr == `MSC1_CFG_OFFSET);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfgWord_ff <= `MSC1_CFG_RESET;
        end else if (cfgWrite) begin
            cfgWord_ff <= wrData & `MSC1_CFG_WR_MASK;
        end
    end

    // reserved cap codes are flagged, sticky until a legal code is written
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            capErr_ff <= 1'b0;
        end else if (cfgWrite) begin
            capErr_ff <= wrData[`MSC1_CAP_MSB:`MSC1_CAP_LSB] > `MSC1_CAP_MAX_CODE;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sequencer
    msc1_pkg::msc1_state_e state_ff;
    msc1_pkg::msc1_state_e nxt_state;
    msc1_pkg::msc1_cfg_s   snap_ff;
    logic [31:0]           msDiv_ff;
    logic [13:0]           msCnt_ff;
    logic [31:0]           pulseCnt_ff;
    logic [1:0]            runCnt_ff;
    logic                  alignExpired;
    logic                  msTick;
    logic                  lastRun;

    assign msTick       = (msDiv_ff == MsLast);
    assign alignExpired = msTick && (msCnt_ff + 14'd1 >= align_ms(snap_ff.alignDuration));
    assign lastRun      = detectRunDone && (runCnt_ff == snap_ff.positionDetectRepeatCount);

    always_comb begin
        nxt_state = state_ff;
        if (stopReq) begin
            nxt_state = msc1_pkg::MSC1_IDLE;
        end else begin
            case (state_ff)
                msc1_pkg::MSC1_IDLE: begin
                    if (startReq) begin
                        case (cfgWord_ff[`MSC1_METHOD_MSB:`MSC1_METHOD_LSB])
                            2'h2:    nxt_state = msc1_pkg::MSC1_DETECT;
                            2'h3:    nxt_state = msc1_pkg::MSC1_SLOW;
                            default: nxt_state = msc1_pkg::MSC1_ALIGN1;
                        endcase
                    end
                end
                msc1_pkg::MSC1_ALIGN1: begin
                    if (alignExpired) begin
                        if (snap_ff.startupMethodSelect == msc1_pkg::MSC1_ALIGN_DOUBLE) begin
                            nxt_state = msc1_pkg::MSC1_ALIGN2;
                        end else begin
                            nxt_state = msc1_pkg::MSC1_RUN;
                        end
                    end
                end
                msc1_pkg::MSC1_ALIGN2: begin
                    if (alignExpired) begin
                        nxt_state = msc1_pkg::MSC1_RUN;
                    end
                end
                msc1_pkg::MSC1_DETECT: begin
                    if (lastRun) begin
                        nxt_state = msc1_pkg::MSC1_RUN;
                    end
                end
                msc1_pkg::MSC1_SLOW: begin
                    if (slowCycleDone) begin
                        nxt_state = msc1_pkg::MSC1_RUN;
                    end
                end
                // run holds until an abort
                msc1_pkg::MSC1_RUN: begin
                    nxt_state = msc1_pkg::MSC1_RUN;
                end
                default: begin
                    nxt_state = msc1_pkg::MSC1_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= msc1_pkg::MSC1_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // snapshot taken at start, frozen until the next start
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            snap_ff <= '0;
        end else if (state_ff == msc1_pkg::MSC1_IDLE && startReq && !stopReq) begin
            snap_ff <= {cfgWord_ff[`MSC1_METHOD_MSB:`MSC1_METHOD_LSB],
                        cfgWord_ff[`MSC1_RAMP_MSB:`MSC1_RAMP_LSB],
                        cfgWord_ff[`MSC1_ALIGN_MSB:`MSC1_ALIGN_LSB],
                        (cfgWord_ff[`MSC1_CAP_MSB:`MSC1_CAP_LSB] > `MSC1_CAP_MAX_CODE) ?
                            `MSC1_CAP_MAX_CODE :
                            cfgWord_ff[`MSC1_CAP_MSB:`MSC1_CAP_LSB],
                        cfgWord_ff[`MSC1_RATE_MSB:`MSC1_RATE_LSB],
                        cfgWord_ff[`MSC1_THR_MSB:`MSC1_THR_LSB],
                        cfgWord_ff[`MSC1_RELEASE_BIT],
                        cfgWord_ff[`MSC1_ANGLE_MSB:`MSC1_ANGLE_LSB],
                        cfgWord_ff[`MSC1_REPEAT_MSB:`MSC1_REPEAT_LSB],
                        cfgWord_ff[`MSC1_OLCFG_BIT],
                        cfgWord_ff[`MSC1_IQRAMP_BIT],
                        cfgWord_ff[`MSC1_BRAKE_BIT],
                        cfgWord_ff[`MSC1_REVSEL_BIT]};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // alignment timer, restarts on each alignment phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            msDiv_ff <= '0;
            msCnt_ff <= '0;
        end else if (nxt_state != state_ff || !(state_ff == msc1_pkg::MSC1_ALIGN1
                     || state_ff == msc1_pkg::MSC1_ALIGN2)) begin
            msDiv_ff <= '0;
            msCnt_ff <= '0;
        end else if (msTick) begin
            msDiv_ff <= '0;
            msCnt_ff <= msCnt_ff + 14'd1;
        end else begin
            msDiv_ff <= msDiv_ff + 32'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // detection pulse generator and run counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulseCnt_ff <= '0;
            detectPulse <= 1'b0;
        end else if (state_ff != msc1_pkg::MSC1_DETECT || nxt_state != state_ff) begin
            pulseCnt_ff <= '0;
            detectPulse <= 1'b0;
        end else if (pulseCnt_ff == '0) begin
            pulseCnt_ff <= pulse_period(snap_ff.positionPulseRate) - 32'd1;
            detectPulse <= 1'b1;
        end else begin
            pulseCnt_ff <= pulseCnt_ff - 32'd1;
            detectPulse <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            runCnt_ff <= '0;
        end else if (state_ff != msc1_pkg::MSC1_DETECT) begin
            runCnt_ff <= '0;
        end else if (detectRunDone) begin
            runCnt_ff <= runCnt_ff + 2'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bridge release after detection, held until the next start
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bridgeBrake    <= 1'b0;
            bridgeTristate <= 1'b0;
        end else if (state_ff == msc1_pkg::MSC1_DETECT && lastRun && !stopReq) begin
            bridgeBrake    <= !snap_ff.positionDetectReleaseBehaviour;
            bridgeTristate <= snap_ff.positionDetectReleaseBehaviour;
        end else if (state_ff == msc1_pkg::MSC1_IDLE && startReq) begin
            bridgeBrake    <= 1'b0;
            bridgeTristate <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registered status outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seqState      <= msc1_pkg::MSC1_IDLE;
            activeCfg     <= '0;
            alignActive   <= 1'b0;
            rampUnlimited <= 1'b0;
            capCodeError  <= 1'b0;
            startupDone   <= 1'b0;
        end else begin
            seqState      <= nxt_state;
            activeCfg     <= snap_ff;
            alignActive   <= nxt_state == msc1_pkg::MSC1_ALIGN1
                             || nxt_state == msc1_pkg::MSC1_ALIGN2;
            rampUnlimited <= snap_ff.rampRate == `MSC1_RAMP_NO_LIMIT;
            capCodeError  <= capErr_ff;
            startupDone   <= nxt_state == msc1_pkg::MSC1_RUN
                             && state_ff != msc1_pkg::MSC1_RUN;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register read port
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData <= '0;
        end else if (rdStb && addr == `MSC1_CFG_OFFSET) begin
            rdData <= cfgWord_ff;
        end else if (rdStb && addr == `MSC1_STAT_OFFSET) begin
            rdData <= {25'h0, capErr_ff, runCnt_ff, 1'b0, state_ff};
        end else begin
            rdData <= '0;
        end
    end

endmodule

// ==== core/msc1_map.svh ====
/*
 * register map, field positions, reset values and timing counts of the
 * first start-up configuration word.
 * assumes: included by bare name; 8-bit byte address, 32-bit data.
 */
`ifndef MSC1_MAP_SVH
`define MSC1_MAP_SVH

////////////////////////////////////////////////////////////////////////
// register offsets
`define MSC1_CFG_OFFSET       8'h84
`define MSC1_STAT_OFFSET      8'h88
`define MSC1_CFG_RESET        32'h00000000
`define MSC1_CFG_WR_MASK      32'h7fffffff

////////////////////////////////////////////////////////////////////////
// field positions of the configuration word
`define MSC1_METHOD_MSB       30
`define MSC1_METHOD_LSB       29
`define MSC1_RAMP_MSB         28
`define MSC1_RAMP_LSB         25
`define MSC1_ALIGN_MSB        24
`define MSC1_ALIGN_LSB        21
`define MSC1_CAP_MSB          20
`define MSC1_CAP_LSB          17
`define MSC1_RATE_MSB         16
`define MSC1_RATE_LSB         14
`define MSC1_THR_MSB          13
`define MSC1_THR_LSB          9
`define MSC1_RELEASE_BIT      8
`define MSC1_ANGLE_MSB        7
`define MSC1_ANGLE_LSB        6
`define MSC1_REPEAT_MSB       5
`define MSC1_REPEAT_LSB       4
`define MSC1_OLCFG_BIT        3
`define MSC1_IQRAMP_BIT       2
`define MSC1_BRAKE_BIT        1
`define MSC1_REVSEL_BIT       0

////////////////////////////////////////////////////////////////////////
// code limits
`define MSC1_CAP_MAX_CODE     4'hd
`define MSC1_RAMP_NO_LIMIT    4'hf

////////////////////////////////////////////////////////////////////////
// timing
`define MSC1_CLK_PERIOD_NS    8
`define MSC1_MS_NS            1000000
`define MSC1_MS_PER_S         1000
`define MSC1_MS_CYCLES       ((`MSC1_MS_NS + `MSC1_CLK_PERIOD_NS - 1) / `MSC1_CLK_PERIOD_NS)

`endif

// ==== core/msc1_pkg.sv ====
/*
 * types of the first start-up configuration block.
 * assumes: constants come from msc1_map.svh.
 */
package msc1_pkg;

    typedef enum logic [1:0] {
        MSC1_ALIGN_SINGLE,
        MSC1_ALIGN_DOUBLE,
        MSC1_POS_DETECT,
        MSC1_SLOW_FIRST
    } msc1_method_e;

    typedef enum logic [2:0] {
        MSC1_IDLE,
        MSC1_ALIGN1,
        MSC1_ALIGN2,
        MSC1_DETECT,
        MSC1_SLOW,
        MSC1_RUN
    } msc1_state_e;

    typedef struct packed {
        msc1_method_e startupMethodSelect;
        logic [3:0]   rampRate;
        logic [3:0]   alignDuration;
        logic [3:0]   alignmentCurrentCap;
        logic [2:0]   positionPulseRate;
        logic [4:0]   detectThreshold;
        logic         positionDetectReleaseBehaviour;
        logic [1:0]   advanceAngle;
        logic [1:0]   positionDetectRepeatCount;
        logic         openLoopLimitSel;
        logic         iqRampDownEn;
        logic         activeBrakeEn;
        logic         reverseProfileSelect;
    } msc1_cfg_s;

endpackage

// ==== dv/msc1_startup_cfg_props.sv ====
/*
 * concurrent checks on the ports of the first start-up configuration block.
 * assumes: bound to msc1_startup_cfg, one clock, reset async active low.
 */
`timescale 1ns/1ps
`include "msc1_map.svh"

module msc1_startup_cfg_props (
    input wire logic                  clk,            // clock
    input wire logic                  rst_n,          // async reset
    input wire logic [7:0]            addr,           // byte address
    input wire logic [31:0]           wrData,         // write data
    input wire logic                  wrStb,          // write strobe
    input wire logic                  rdStb,          // read strobe
    input wire logic [31:0]           rdData,         // read data
    input wire logic                  startReq,       // start request
    input wire logic                  stopReq,        // abort
    input wire msc1_pkg::msc1_cfg_s   activeCfg,      // held snapshot
    input wire msc1_pkg::msc1_state_e seqState,       // sequencer state
    input wire logic                  alignActive,    // alignment on
    input wire logic                  detectPulse,    // detection pulse
    input wire logic                  bridgeBrake,    // phases braked
    input wire logic                  bridgeTristate, // phases released
    input wire logic                  rampUnlimited,  // no ramp limit
    input wire logic                  capCodeError,   // reserved cap code
    input wire logic                  startupDone     // start-up finished
);
    logic [31:0] cfgShadow_ff; // last word written to the config offset

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfgShadow_ff <= 32'h00000000;
        end else if (wrStb && addr == `MSC1_CFG_OFFSET) begin
            cfgShadow_ff <= wrData;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////
    rd_idle_zero_a: assert property (!$past(rdStb) |-> rdData == 32'h0)
        else $error("read data not zero outside read cycle");
    cfg_readback_a: assert property (rdStb && addr == `MSC1_CFG_OFFSET
        |=> rdData == ($past(cfgShadow_ff) & `MSC1_CFG_WR_MASK))
        else $error("config read back differs from write");
    unmapped_rd_a: assert property (rdStb && addr != `MSC1_CFG_OFFSET
        && addr != `MSC1_STAT_OFFSET |=> rdData == 32'h0)
        else $error("unmapped read not zero");
    method_map_a: assert property (seqState == msc1_pkg::MSC1_IDLE
        && startReq && !stopReq
        |=> seqState == (($past(cfgShadow_ff[30:29]) == 2'h2) ? msc1_pkg::MSC1_DETECT :
        ($past(cfgShadow_ff[30:29]) == 2'h3) ? msc1_pkg::MSC1_SLOW : msc1_pkg::MSC1_ALIGN1))
        else $error("wrong first state for method");
    align_flag_a: assert property (alignActive == (seqState inside
        {msc1_pkg::MSC1_ALIGN1, msc1_pkg::MSC1_ALIGN2}))
        else $error("alignment flag out of step with state");
    align_time_a: assert property (@(posedge clk) disable iff (!rst_n || stopReq)
        seqState == msc1_pkg::MSC1_IDLE && startReq && cfgShadow_ff[30:29] == 2'h0
        && cfgShadow_ff[24:21] == 4'h0 |=> ##39 seqState == msc1_pkg::MSC1_ALIGN1
        ##1 seqState == msc1_pkg::MSC1_RUN)
        else $error("shortest alignment not 40 cycles");
    done_pulse_a: assert property (startupDone |-> seqState == msc1_pkg::MSC1_RUN
        ##1 !startupDone)
        else $error("done pulse misplaced");
    cfg_hold_a: assert property ((seqState inside {msc1_pkg::MSC1_ALIGN1,
        msc1_pkg::MSC1_ALIGN2, msc1_pkg::MSC1_DETECT, msc1_pkg::MSC1_SLOW})
        && $past(seqState) != msc1_pkg::MSC1_IDLE
        && $past(seqState, 2) != msc1_pkg::MSC1_IDLE |-> $stable(activeCfg))
        else $error("snapshot changed during start-up");
    cap_flag_a: assert property (wrStb && addr == `MSC1_CFG_OFFSET
        |=> ##1 capCodeError == ($past(wrData[20:17], 2) > 4'hd))
        else $error("cap code flag wrong");
    cap_clamp_a: assert property (activeCfg.alignmentCurrentCap <= 4'hd)
        else $error("reserved cap code in snapshot");
    ramp_flag_a: assert property (rampUnlimited == (activeCfg.rampRate == 4'hf))
        else $error("ramp unlimited flag wrong");
    bridge_mode_a: assert property ($rose(bridgeBrake || bridgeTristate) |->
        bridgeTristate == activeCfg.positionDetectReleaseBehaviour
        && bridgeBrake != bridgeTristate)
        else $error("bridge release mode wrong");
    detect_first_a: assert property (seqState == msc1_pkg::MSC1_DETECT
        && $past(seqState) != msc1_pkg::MSC1_DETECT
        ##1 seqState == msc1_pkg::MSC1_DETECT |-> detectPulse)
        else $error("no pulse on detection entry");

    align_run_c: cover property (seqState == msc1_pkg::MSC1_ALIGN2
        ##1 seqState == msc1_pkg::MSC1_RUN);
    detect_run_c: cover property (seqState == msc1_pkg::MSC1_DETECT
        ##1 seqState == msc1_pkg::MSC1_RUN);
    cap_err_c: cover property ($rose(capCodeError));
endmodule

bind msc1_startup_cfg msc1_startup_cfg_props i_msc1_startup_cfg_props (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
    .rdData(rdData), .startReq(startReq), .stopReq(stopReq), .activeCfg(activeCfg),
    .seqState(seqState), .alignActive(alignActive), .detectPulse(detectPulse),
    .bridgeBrake(bridgeBrake), .bridgeTristate(bridgeTristate), .rampUnlimited(rampUnlimited),
    .capCodeError(capCodeError), .startupDone(startupDone));

// ==== dv/tb_msc1_startup_cfg.sv ====
/*
 * self-checking bench of the first start-up configuration block.
 * assumes: design built with CYCLES_PER_MS = 4, 8 ns clock.
 */
`timescale 1ns/1ps
`include "msc1_map.svh"

`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errorCnt++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end

module tb_msc1_startup_cfg;
    logic clk = 0, rst_n = 0, wrStb = 0, rdStb = 0;
    logic startReq = 0, stopReq = 0, detectRunDone = 0, slowCycleDone = 0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wrData = 32'h0, rdData;
    logic alignActive, detectPulse, bridgeBrake, bridgeTristate;
    logic rampUnlimited, capCodeError, startupDone;
    msc1_pkg::msc1_cfg_s activeCfg;
    msc1_pkg::msc1_state_e seqState;
    int errorCnt = 0, compares = 0, n;
    logic [30:0] snap;
    logic [31:0] rows[5] = '{32'h1e000000, 32'ha03c0000, 32'h401fc123, 32'h40000030, 32'h600000cc};
    int cyc[5] = '{40, 400, 0, 0, 0};

    msc1_startup_cfg #(.CYCLES_PER_MS(4)) i_msc1_startup_cfg (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrStb(wrStb),
        .rdStb(rdStb), .rdData(rdData), .startReq(startReq), .stopReq(stopReq),
        .detectRunDone(detectRunDone), .slowCycleDone(slowCycleDone), .activeCfg(activeCfg),
        .seqState(seqState), .alignActive(alignActive), .detectPulse(detectPulse),
        .bridgeBrake(bridgeBrake), .bridgeTristate(bridgeTristate),
        .rampUnlimited(rampUnlimited), .capCodeError(capCodeError), .startupDone(startupDone));

    initial begin
        forever #4 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a; wrData <= d; wrStb <= 1'b1;
        @(posedge clk);
        wrStb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a; rdStb <= 1'b1;
        @(posedge clk);
        rdStb <= 1'b0;
        #1 `CHK("rdData", e, rdData)
    endtask

    // one-cycle pulse: 0 start, 1 stop, 2 detection run done, 3 slow cycle done
    task automatic kick(input int w);
        @(posedge clk);
        case (w)
            0: startReq <= 1'b1;
            1: stopReq <= 1'b1;
            2: detectRunDone <= 1'b1;
            default: slowCycleDone <= 1'b1;
        endcase
        @(posedge clk);
        {startReq, stopReq, detectRunDone, slowCycleDone} <= 4'h0;
        #1;
    endtask

    task automatic wait_run();
        n = 0;
        while (seqState !== msc1_pkg::MSC1_RUN && n < 2000) begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= 2000) begin
            errorCnt++;
            tally_and_finish();
        end
        `CHK("startupDone", 1'b1, startupDone)
    endtask

    task automatic tally_and_finish();
        $display("compares %0d errorCnt %0d", compares, errorCnt);
        if (errorCnt == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd(`MSC1_CFG_OFFSET, 32'h0);
        for (int i = 0; i < 5; i++) begin
            wr(`MSC1_CFG_OFFSET, rows[i]);
            rd(`MSC1_CFG_OFFSET, rows[i] & `MSC1_CFG_WR_MASK);
            `CHK("capCodeError", rows[i][20:17] > 4'hd, capCodeError)
            snap = rows[i][30:0];
            if (snap[20:17] > 4'hd) snap[20:17] = 4'hd;
            kick(0);
            case (rows[i][30:29])
                2'h2: begin
                    `CHK("seqState", msc1_pkg::MSC1_DETECT, seqState)
                    for (int k = 0; k < rows[i][5:4]; k++) begin
                        kick(2);
                        `CHK("seqState", msc1_pkg::MSC1_DETECT, seqState)
                    end
                    kick(2);
                end
                2'h3: begin
                    `CHK("seqState", msc1_pkg::MSC1_SLOW, seqState)
                    kick(3);
                end
                default: `CHK("seqState", msc1_pkg::MSC1_ALIGN1, seqState)
            endcase
            wait_run();
            if (cyc[i] != 0) `CHK("alignCycles", cyc[i], n)
            if (rows[i][30:29] == 2'h2) begin
                `CHK("bridgeTristate", rows[i][8], bridgeTristate)
                `CHK("bridgeBrake", !rows[i][8], bridgeBrake)
            end
            `CHK("activeCfg", msc1_pkg::msc1_cfg_s'(snap), activeCfg)
            `CHK("rampUnlimited", rows[i][28:25] == 4'hf, rampUnlimited)
            kick(1);
            `CHK("seqState", msc1_pkg::MSC1_IDLE, seqState)
        end
        // reconfigure and restart in mid-alignment: neither may disturb it
        wr(`MSC1_CFG_OFFSET, 32'h1e000000);
        kick(0);
        wr(`MSC1_CFG_OFFSET, 32'h60000000);
        kick(0);
        wait_run();
        `CHK("alignCycles", 40, n + 4)
        `CHK("method", msc1_pkg::MSC1_ALIGN_SINGLE, activeCfg.startupMethodSelect)
        // status: state run, no detection runs, no cap flag
        rd(`MSC1_STAT_OFFSET, 32'h00000005);
        rd(8'h90, 32'h0);
        // reset in mid-run clears the word and the sequencer
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(`MSC1_CFG_OFFSET, 32'h0);
        `CHK("seqState", msc1_pkg::MSC1_IDLE, seqState)
        tally_and_finish();
    end
endmodule
